// ===== rtl/acf_top.sv
/*
 * Converter clock prescaler, result justification and result byte pair
 * with read interlock, behind an AXI4-Lite slave.
 * Assumes the conversion core supplies a one-cycle done strobe with the
 * 10-bit result, and that the external oscillator arrives as a pin.
 */
`default_nettype none
module acf_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_oscillator_clock,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_result,
  input  wire logic        status_control_wr,
  output logic             converter_clock_en,
  output logic             conversion_done_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Register decode.

  function automatic logic is_reg(input logic [9:0] a, input logic [7:0] idx);
    is_reg = (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  logic              aw_held_reg;
  logic              w_held_reg;
  logic [9:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  acf_pkg::acf_clkctl_s clkctl_reg;
  logic [7:0]        high_reg;
  logic [7:0]        low_reg;
  logic              lock_reg;
  logic              osc_meta_reg;
  logic              osc_sync_reg;
  logic              osc_prev_reg;
  logic [3:0]        presc_reg;
  logic [7:0]        clkctl_byte;

  wire        wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire        wr_clkctl = wr_fire && is_reg(aw_addr_reg, acf_pkg::IDX_CLOCK_CONTROL)
                          && w_strb_reg[0];
  wire        wr_status = wr_fire && is_reg(aw_addr_reg, acf_pkg::IDX_STATUS_CONTROL);
  wire        wr_known  = is_reg(aw_addr_reg, acf_pkg::IDX_CLOCK_CONTROL)
                       || is_reg(aw_addr_reg, acf_pkg::IDX_RESULT_HIGH)
                       || is_reg(aw_addr_reg, acf_pkg::IDX_RESULT_LOW)
                       || is_reg(aw_addr_reg, acf_pkg::IDX_STATUS_CONTROL);
  wire        rd_fire   = s_axi_arvalid && s_axi_arready;
  wire        rd_high   = rd_fire && is_reg(s_axi_araddr, acf_pkg::IDX_RESULT_HIGH);
  wire        rd_low    = rd_fire && is_reg(s_axi_araddr, acf_pkg::IDX_RESULT_LOW);
  wire        rd_clk    = is_reg(s_axi_araddr, acf_pkg::IDX_CLOCK_CONTROL);
  wire        rd_stat   = is_reg(s_axi_araddr, acf_pkg::IDX_STATUS_CONTROL);
  wire        rd_known  = rd_clk || rd_stat
                       || is_reg(s_axi_araddr, acf_pkg::IDX_RESULT_HIGH)
                       || is_reg(s_axi_araddr, acf_pkg::IDX_RESULT_LOW);

  assign clkctl_byte = {clkctl_reg.divide, clkctl_reg.source, clkctl_reg.justify, 2'h0};

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, then a response.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 10'h000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? acf_pkg::RESP_OKAY : acf_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  ////////////////////////////////////////////////////////////////////////
  // Clock control register. Result byte writes fall through untouched.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clkctl_reg.divide  <= acf_pkg::DIV_RESET;
      clkctl_reg.source  <= acf_pkg::SRC_RESET;
      clkctl_reg.justify <= acf_pkg::JUST_RESET;
    end else if (wr_clkctl) begin
      clkctl_reg.divide  <= w_data_reg[acf_pkg::DIV_MSB:acf_pkg::DIV_LSB];
      clkctl_reg.source  <= w_data_reg[acf_pkg::SRC_BIT];
      clkctl_reg.justify <= acf_pkg::acf_just_e'(w_data_reg[acf_pkg::JUST_MSB:acf_pkg::JUST_LSB]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler. Both sources become enables in the aclk domain; the
  // oscillator is synchronised and edge-detected, so it must stay well
  // below half the bus clock.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= external_oscillator_clock;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  wire src_tick = clkctl_reg.source ? 1'b1 : (osc_sync_reg && !osc_prev_reg);

  // Terminal count: 0, 1, 3, 7 or 15 for divide by 1, 2, 4, 8, 16.
  wire [3:0] presc_max = clkctl_reg.divide[2] ? 4'hF :
                         4'((5'h01 << clkctl_reg.divide[1:0]) - 5'h01);
  wire presc_wrap = src_tick && (presc_reg >= presc_max);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg          <= 4'h0;
      converter_clock_en <= 1'b0;
    end else begin
      converter_clock_en <= presc_wrap;
      if (wr_clkctl || presc_wrap) begin
        presc_reg <= 4'h0;
      end else if (src_tick) begin
        presc_reg <= presc_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result formatting and interlock.

  wire trunc_mode = (clkctl_reg.justify == acf_pkg::ACF_TRUNC8);
  logic [7:0] high_next;
  logic [7:0] low_next;

  // The layout is chosen from the mode in force at the completing edge, so a
  // mode change lands on the next result and never re-packs a stored one.
  always_comb begin
    unique case (clkctl_reg.justify)
      acf_pkg::ACF_TRUNC8: begin
        high_next = 8'h00;
        low_next  = conv_result[9:2];
      end
      acf_pkg::ACF_RIGHT: begin
        high_next = {6'h00, conv_result[9:8]};
        low_next  = conv_result[7:0];
      end
      acf_pkg::ACF_LEFT: begin
        high_next = conv_result[9:2];
        low_next  = {conv_result[1:0], 6'h00};
      end
      acf_pkg::ACF_LEFT_SG: begin
        high_next = {~conv_result[9], conv_result[8:2]};
        low_next  = {conv_result[1:0], 6'h00};
      end
    endcase
  end

  wire lock_release = rd_low || wr_status || status_control_wr || wr_clkctl;
  wire take_result  = conv_done && (trunc_mode || !lock_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_reg <= 8'h00;
      low_reg  <= 8'h00;
      lock_reg <= 1'b0;
    end else begin
      if (take_result) begin
        high_reg <= high_next;
        low_reg  <= low_next;
      end
      if (lock_release) begin
        lock_reg <= 1'b0;
      end else if (rd_high && !trunc_mode) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // The done flag is set by a taken result; the set wins over a clear.
  // A dropped result under the lock leaves the flag alone, so software that
  // polls the flag never sees a completion whose data it cannot read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_done_flag <= 1'b0;
    end else if (take_result) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_clkctl || wr_status || status_control_wr || rd_low) begin
      conversion_done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data.

  wire [7:0] rd_byte = rd_clk ? clkctl_byte :
                       rd_stat ? {conversion_done_flag, 7'h00} :
                       is_reg(s_axi_araddr, acf_pkg::IDX_RESULT_HIGH) ? high_reg :
                       is_reg(s_axi_araddr, acf_pkg::IDX_RESULT_LOW) ? low_reg : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= acf_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_known ? acf_pkg::RESP_OKAY : acf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  lock_drops_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lock_reg && conv_done && !trunc_mode) |=> $stable(high_reg) && $stable(low_reg))
    else $error("result changed while locked");
  trunc_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && trunc_mode) |=> high_reg == 8'h00 && low_reg == $past(conv_result[9:2]))
    else $error("truncated layout wrong");
  sign_flip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take_result && clkctl_reg.justify == acf_pkg::ACF_LEFT_SG)
    |=> high_reg[7] != $past(conv_result[9]))
    else $error("sign bit not inverted");
  release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_clkctl && !take_result) |=> !lock_reg && !conversion_done_flag)
    else $error("clock control write did not release");
  right_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (take_result && clkctl_reg.justify == acf_pkg::ACF_RIGHT)
    |=> high_reg == {6'h00, $past(conv_result[9:8])} && low_reg == $past(conv_result[7:0]))
    else $error("right justified layout wrong");
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    take_result |=> conversion_done_flag)
    else $error("done flag not set by a taken result");
  divide_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clkctl_reg.source && clkctl_reg.divide[2] && converter_clock_en && !wr_clkctl)
    |=> !converter_clock_en [*8])
    else $error("divide by sixteen too fast");
endmodule
`default_nettype wire

// ===== rtl/acf_pkg.sv
/*
 * Package for the converter clock and result format block: register
 * indices, field positions, reset values and the justification modes.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
`default_nettype none
package acf_pkg;

  // Printed offsets are not multiples of four, so they are indices.
  localparam logic [7:0] IDX_CLOCK_CONTROL  = 8'h58;
  localparam logic [7:0] IDX_RESULT_HIGH    = 8'h59;
  localparam logic [7:0] IDX_RESULT_LOW     = 8'h5A;
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h57;
  localparam int         ADDR_W             = 10;

  // Clock control field positions, and the done bit of the status register.
  localparam int DIV_LSB    = 5;
  localparam int DIV_MSB    = 7;
  localparam int SRC_BIT    = 4;
  localparam int JUST_LSB   = 2;
  localparam int JUST_MSB   = 3;
  localparam int DONE_BIT   = 7;

  typedef enum logic [1:0] {
    ACF_TRUNC8  = 2'h0,
    ACF_RIGHT   = 2'h1,
    ACF_LEFT    = 2'h2,
    ACF_LEFT_SG = 2'h3
  } acf_just_e;

  localparam logic [2:0] DIV_RESET   = 3'h0;
  localparam logic       SRC_RESET   = 1'b0;
  localparam acf_just_e  JUST_RESET  = ACF_RIGHT;
  localparam int         PRESC_W     = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] divide;
    logic       source;
    acf_just_e  justify;
  } acf_clkctl_s;

endpackage
`default_nettype wire

// ===== sim/tb_acf_top.sv
/*
 * Self-checking bench for acf_top: register access, result layouts,
 * read interlock and prescaler rates.
 * Assumes the bus timing given with the design and a single clock.
 */
`default_nettype none
module tb_acf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, osc, cdone, scwr, cken, flag;
  logic [9:0]  awaddr, araddr, cres, v, w;
  logic [31:0] wdata, rdata, seed, t;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, oc;
  logic [15:0] e;
  int          errors, checks;
  localparam logic [9:0] A_CLK = {acf_pkg::IDX_CLOCK_CONTROL, 2'b00};
  localparam logic [9:0] A_HI  = {acf_pkg::IDX_RESULT_HIGH, 2'b00};
  localparam logic [9:0] A_LO  = {acf_pkg::IDX_RESULT_LOW, 2'b00};

  acf_top u_acf_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_oscillator_clock(osc), .conv_done(cdone), .conv_result(cres),
    .status_control_wr(scwr), .converter_clock_en(cken), .conversion_done_flag(flag));

////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Oscillator at a quarter of aclk, slow enough for the two-flop synchroniser.
  always @(posedge aclk) begin
    oc <= oc + 2'h1;
    osc <= oc[1];
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'h0: return {8'h00, r[9:2]};
      2'h1: return {6'h00, r};
      2'h2: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction

////////////////////////////////////////////////////////////////////////////////
  task cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // Handshakes are judged at the falling edge, where they are settled, and acted on
  // at the following rising edge, so combinational readies cannot race the bench.
  task wr(input logic [9:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
    cmp({30'h0, resp}, {30'h0, acf_pkg::RESP_OKAY});
  endtask

  task rd(input logic [9:0] a, input logic [31:0] x, input logic [1:0] xr);
    logic ah, rh;
    logic [31:0] d;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
    cmp(d, x);
    cmp({30'h0, resp}, {30'h0, xr});
  endtask

  task rdb(input logic hi, input logic [1:0] m, input logic [9:0] r);
    e = fmt(m, r);
    rd(hi ? A_HI : A_LO, {24'h0, hi ? e[15:8] : e[7:0]}, acf_pkg::RESP_OKAY);
  endtask

  task conv(input logic [9:0] r);
    @(posedge aclk);
    cdone <= 1'b1;
    cres <= r;
    @(posedge aclk);
    cdone <= 1'b0;
    cres <= ~r;
    @(posedge aclk);
  endtask

  task per(input int x);
    int n;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (cken !== 1'b1 && n < 100);
    end
    cmp(n, x);
  endtask

  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge aclk);
    errors++;
    results();
  end

  initial begin
    seed = 32'hAC5C6375; errors = 0; checks = 0; oc = 2'h0; osc = 1'b0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; cdone = 1'b0; scwr = 1'b0; wstrb = 4'hF; awaddr = 10'h0;
    araddr = 10'h0; wdata = 32'h0; cres = 10'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CLK, 32'h04, acf_pkg::RESP_OKAY);
    rd(A_HI, 32'h0, acf_pkg::RESP_OKAY);
    rd(A_LO, 32'h0, acf_pkg::RESP_OKAY);
    rd(10'h3F0, 32'h0, acf_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(A_CLK, {24'h0, 4'h1, m[1:0], 2'h0});
      for (int k = 0; k < 4; k++) begin
        t = rnd();
        v = (k == 0) ? 10'h3FF : (k == 1) ? 10'h200 : t[9:0];
        conv(v);
        cmp({31'h0, flag}, 32'h1);
        rdb(1'b1, m[1:0], v);
        rdb(1'b0, m[1:0], v);
      end
    end
    $display("test layouts done");
    wr(A_CLK, 32'h14);
    t = rnd();
    v = t[9:0];
    w = ~v;
    conv(v);
    rdb(1'b1, 2'h1, v);
    conv(w);
    rdb(1'b0, 2'h1, v);
    rdb(1'b1, 2'h1, v);
    @(posedge aclk) scwr <= 1'b1;
    @(posedge aclk) scwr <= 1'b0;
    conv(w);
    rdb(1'b0, 2'h1, w);
    conv(v);
    rdb(1'b1, 2'h1, v);
    wr(A_CLK, 32'h14);
    cmp({31'h0, flag}, 32'h0);
    conv(w);
    rdb(1'b1, 2'h1, w);
    rdb(1'b1, 2'h1, w);
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    conv(v);
    rdb(1'b0, 2'h1, v);
    $display("test interlock done");
    wr(A_CLK, 32'h10);
    conv(v);
    rdb(1'b1, 2'h0, v);
    conv(w);
    rdb(1'b0, 2'h0, w);
    wr(A_LO, 32'hFF);
    wr(A_HI, 32'hFF);
    rdb(1'b0, 2'h0, w);
    rdb(1'b1, 2'h0, w);
    $display("test truncated done");
    foreach (e[i]) if (i < 8 && i != 5 && i != 6) begin
      wr(A_CLK, {24'h0, i[2:0], 5'h14});
      per(i[2] ? 16 : (1 << i));
    end
    wr(A_CLK, 32'h24);
    per(8);
    $display("test prescaler done");
    results();
  end
endmodule
`default_nettype wire
